// ==== design/ppio_pkg.sv ====
// Constants, register map and pin grouping for the parallel port pin block
package ppio_pkg;
    localparam int PW         = 17;
    localparam int MAX_PORTS  = 8;
    localparam int ADDR_W     = 9;
    localparam int CLK_PERIOD_NS = 10;
    // Bits 0-7 data group, 8-11 control group, 12-16 status group
    localparam logic [16:0] DATA_MASK = 17'h000FF;
    localparam logic [16:0] CTRL_MASK = 17'h00F00;
    localparam logic [16:0] STAT_MASK = 17'h1F000;
    // Direction modes; zero is the default output mode
    localparam logic [1:0] MODE_OUT = 2'h0;
    localparam logic [1:0] MODE_IN  = 2'h1;
    localparam logic [1:0] MODE_EPP = 2'h2;
    localparam logic [1:0] MODE_X   = 2'h3;
    // Per-port registers, port number in address bits 7:5
    localparam int PORT_SHIFT = 5;
    localparam logic [4:0] REG_OUT = 5'h00;
    localparam logic [4:0] REG_INV = 5'h04;
    localparam logic [4:0] REG_RST = 5'h08;
    localparam logic [4:0] REG_IN  = 5'h0C;
    localparam logic [4:0] REG_INN = 5'h10;
    localparam logic [4:0] REG_DIR = 5'h14;
    localparam logic [8:0] REG_RTIME = 9'h100;
    localparam logic [8:0] REG_STAT  = 9'h104;
    localparam logic [31:0] RTIME_RESET = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    function automatic logic [16:0] out_mask(input logic [1:0] m);
        case (m)
            MODE_IN: out_mask = CTRL_MASK;
            MODE_X:  out_mask = DATA_MASK;
            default: out_mask = DATA_MASK | CTRL_MASK;
        endcase
    endfunction

    // Least time rounds up, never below one cycle
    function automatic logic [31:0] ns_to_cycles(input logic [31:0] ns);
        logic [32:0] t;
        t = ({1'b0, ns} + 33'(CLK_PERIOD_NS - 1)) / 33'(CLK_PERIOD_NS);
        ns_to_cycles = (t == 33'h0) ? 32'h0000_0001 : t[31:0];
    endfunction
endpackage

// ==== design/ppio_top.sv ====
// Parallel port pin block with AXI4-Lite registers
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps

// Notes on behaviour
// - Up to eight ports, each with its own direction mode.
// - A port without a given mode works in output mode.
// - Input mode: data group inputs, thirteen inputs and four outputs.
// - Output mode: data group outputs, five inputs and twelve outputs.
// - Enhanced mode equals output mode, only requesting another port setting.
// - Open-collector mode: control group inputs, eight outputs, nine inputs.
// - Input value is true for a high pin, false for low.
// - Inverted input copy is false for a high pin, true for low.
// - Per output pin invert bit flips the driven level.
// - Per output pin enable marks it for return after a write.
// - A 32-bit delay in nanoseconds times the return after a write.
// - After the delay, enabled output pins take their invert bit value.
// - The return always follows the write of the same update.
// - Read samples input pins, updating true and inverted values together.
// - Write applies inversion to requested values and drives output pins.
// - Port direction stays fixed once configured.
// - Seventeen pins: eight data, four control (inputs in open-collector mode), five status inputs.
// - Ports are numbered consecutively from zero.
module ppio_top #(
    parameter int          NPORT      = ppio_pkg::MAX_PORTS,
    parameter logic [15:0] PORT_MODES = 16'h0000
) (
    input  wire logic                             CLK_SYS,
    input  wire logic                             NRST,
    input  wire logic                             CE,
    input  wire logic                             UPDATE,
    input  wire logic [NPORT*ppio_pkg::PW-1:0]    PIN_I,
    output logic      [NPORT*ppio_pkg::PW-1:0]    PIN_O,
    output logic      [NPORT*ppio_pkg::PW-1:0]    PIN_OE,
    output logic      [NPORT-1:0]                 EPP_REQ,
    input  wire logic [ppio_pkg::ADDR_W-1:0]      S_AXI_AWADDR,
    input  wire logic                             S_AXI_AWVALID,
    output logic                                  S_AXI_AWREADY,
    input  wire logic [31:0]                      S_AXI_WDATA,
    input  wire logic [3:0]                       S_AXI_WSTRB,
    input  wire logic                             S_AXI_WVALID,
    output logic                                  S_AXI_WREADY,
    output logic [1:0]                            S_AXI_BRESP,
    output logic                                  S_AXI_BVALID,
    input  wire logic                             S_AXI_BREADY,
    input  wire logic [ppio_pkg::ADDR_W-1:0]      S_AXI_ARADDR,
    input  wire logic                             S_AXI_ARVALID,
    output logic                                  S_AXI_ARREADY,
    output logic [31:0]                           S_AXI_RDATA,
    output logic [1:0]                            S_AXI_RRESP,
    output logic                                  S_AXI_RVALID,
    input  wire logic                             S_AXI_RREADY
);
    import ppio_pkg::*;

    logic [1:0]        rst_sync;
    logic              rst_n;
    logic [NPORT*PW-1:0] pin_s1;
    logic [NPORT*PW-1:0] pin_s2;
    logic [PW-1:0]     out_val [NPORT];
    logic [PW-1:0]     inv     [NPORT];
    logic [PW-1:0]     rst_en  [NPORT];
    logic [PW-1:0]     in_true [NPORT];
    logic [PW-1:0]     in_not  [NPORT];
    logic [31:0]       rtime;
    logic [31:0]       cnt;
    logic              pending;
    logic              upd;
    logic              done;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              aw_held;
    logic              w_held;
    logic              do_write;

    function automatic logic [1:0] mode_of(input int p);
        mode_of = PORT_MODES[2*p +: 2];
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        merge = r;
    endfunction

    function automatic logic addr_ok(input logic [ADDR_W-1:0] a, input logic wr);
        logic [4:0] off;
        off = a[4:0];
        if (a[8]) begin
            addr_ok = (a == REG_RTIME) || (!wr && a == REG_STAT);
        end else if (int'(a[7:PORT_SHIFT]) >= NPORT) begin
            addr_ok = 1'b0;
        end else begin
            addr_ok = (off == REG_OUT) || (off == REG_INV) || (off == REG_RST)
                || (!wr && (off == REG_IN || off == REG_INN || off == REG_DIR));
        end
    endfunction

    // Reset release through two flops
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Pins come from outside the clock domain
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else if (CE) begin
            pin_s1 <= PIN_I;
            pin_s2 <= pin_s1;
        end
    end

    assign upd  = UPDATE & CE;
    // Return never in a write cycle
    assign done = CE & pending & (cnt == 32'h0000_0001) & ~UPDATE;
    assign do_write = aw_held & w_held & ~S_AXI_BVALID;

    // Mode code zero is output mode
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            for (int p = 0; p < NPORT; p++) begin
                PIN_OE[p*PW +: PW] <= out_mask(mode_of(p));
                EPP_REQ[p] <= (mode_of(p) == MODE_EPP);
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            for (int p = 0; p < NPORT; p++) begin
                in_true[p] <= '0;
                in_not[p]  <= '0;
            end
        end else if (upd) begin
            for (int p = 0; p < NPORT; p++) begin
                in_true[p] <= pin_s2[p*PW +: PW] & ~out_mask(mode_of(p));
                in_not[p]  <= ~pin_s2[p*PW +: PW] & ~out_mask(mode_of(p));
            end
        end
    end

    // Pin driver: write on the strobe, return on delay expiry
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            PIN_O <= '0;
        end else if (upd) begin
            for (int p = 0; p < NPORT; p++) begin
                PIN_O[p*PW +: PW] <= (out_val[p] ^ inv[p]) & out_mask(mode_of(p));
            end
        end else if (done) begin
            for (int p = 0; p < NPORT; p++) begin
                PIN_O[p*PW +: PW] <= (PIN_O[p*PW +: PW] & ~(rst_en[p] & out_mask(mode_of(p))))
                    | (inv[p] & rst_en[p] & out_mask(mode_of(p)));
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            cnt     <= 32'h0000_0000;
            pending <= 1'b0;
        end else if (upd) begin
            cnt     <= ns_to_cycles(rtime);
            pending <= 1'b1;
        end else if (done) begin
            pending <= 1'b0;
        end else if (CE && pending) begin
            cnt <= cnt - 32'h0000_0001;
        end
    end

    // Write channel handshake; address and data in either order
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= RESP_OKAY;
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else if (CE) begin
            if (!aw_held && !S_AXI_AWREADY) begin
                S_AXI_AWREADY <= 1'b1;
            end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                S_AXI_AWREADY <= 1'b0;
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
            end
            if (!w_held && !S_AXI_WREADY) begin
                S_AXI_WREADY <= 1'b1;
            end else if (S_AXI_WVALID && S_AXI_WREADY) begin
                S_AXI_WREADY <= 1'b0;
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
            end
            if (do_write) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= addr_ok(aw_addr, 1'b1) ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
                aw_held <= 1'b0;
                w_held  <= 1'b0;
            end
        end
    end

    // Port index from address, first port zero
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            rtime <= RTIME_RESET;
            for (int p = 0; p < NPORT; p++) begin
                out_val[p] <= '0;
                inv[p]     <= '0;
                rst_en[p]  <= '0;
            end
        end else if (CE && do_write && addr_ok(aw_addr, 1'b1)) begin
            if (aw_addr == REG_RTIME) begin
                rtime <= merge(rtime, w_data, w_strb);
            end else begin
                for (int p = 0; p < NPORT; p++) begin
                    if (int'(aw_addr[7:PORT_SHIFT]) == p) begin
                        case (aw_addr[4:0])
                            REG_OUT: out_val[p] <= PW'(merge(32'(out_val[p]), w_data, w_strb));
                            REG_INV: inv[p]     <= PW'(merge(32'(inv[p]), w_data, w_strb));
                            REG_RST: rst_en[p]  <= PW'(merge(32'(rst_en[p]), w_data, w_strb));
                            default: ;
                        endcase
                    end
                end
            end
        end
    end

    // Read channel answers one cycle after the address is taken
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0000_0000;
            S_AXI_RRESP   <= RESP_OKAY;
        end else if (CE) begin
            if (!S_AXI_RVALID && !S_AXI_ARREADY) begin
                S_AXI_ARREADY <= 1'b1;
            end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_ARREADY <= 1'b0;
                S_AXI_RVALID  <= 1'b1;
                S_AXI_RRESP   <= addr_ok(S_AXI_ARADDR, 1'b0) ? RESP_OKAY : RESP_SLVERR;
                S_AXI_RDATA   <= 32'h0000_0000;
                if (S_AXI_ARADDR == REG_RTIME) begin
                    S_AXI_RDATA <= rtime;
                end else if (S_AXI_ARADDR == REG_STAT) begin
                    S_AXI_RDATA <= {31'h0000_0000, pending};
                end else if (addr_ok(S_AXI_ARADDR, 1'b0)) begin
                    for (int p = 0; p < NPORT; p++) begin
                        if (int'(S_AXI_ARADDR[7:PORT_SHIFT]) == p) begin
                            case (S_AXI_ARADDR[4:0])
                                REG_OUT: S_AXI_RDATA <= 32'(out_val[p]);
                                REG_INV: S_AXI_RDATA <= 32'(inv[p]);
                                REG_RST: S_AXI_RDATA <= 32'(rst_en[p]);
                                REG_IN:  S_AXI_RDATA <= 32'(in_true[p]);
                                REG_INN: S_AXI_RDATA <= 32'(in_not[p]);
                                REG_DIR: S_AXI_RDATA <= 32'(out_mask(mode_of(p)));
                                default: ;
                            endcase
                        end
                    end
                end
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!rst_n);

    AST_OE_FIXED: assert property ($stable(PIN_OE))
        else $error("pin direction changed");
    AST_DELAY_LOAD: assert property (upd |=> pending && cnt == ns_to_cycles($past(rtime)))
        else $error("delay not loaded on write");
    // A one-cycle delay returns the edge after the write, before pending was seen high
    AST_RET_AFTER_WRITE: assert property (done |-> pending && !upd && ($past(pending) || $past(upd)))
        else $error("return without preceding write");
    AST_DELAY_ONE: assert property (upd && rtime == 32'h0000_0000 ##1 !UPDATE && CE |-> done)
        else $error("zero delay not one cycle");
    AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("write answer dropped");

    for (genvar g = 0; g < NPORT; g++) begin : g_chk
        AST_STAT_IN: assert property ((PIN_OE[g*PW +: PW] & STAT_MASK) == '0)
            else $error("status pin driven");
        AST_IN_PAIR: assert property (upd |=> (in_true[g] ^ in_not[g]) == ~PIN_OE[g*PW +: PW])
            else $error("inverted input mismatch");
        AST_READ: assert property (upd |=> in_true[g] == ($past(pin_s2[g*PW +: PW]) & ~PIN_OE[g*PW +: PW]))
            else $error("input sample wrong");
        AST_WRITE: assert property (upd |=> PIN_O[g*PW +: PW]
            == ($past(out_val[g] ^ inv[g]) & PIN_OE[g*PW +: PW]))
            else $error("output write wrong");
        AST_RETURN: assert property (done |=> ((PIN_O[g*PW +: PW] ^ inv[g]) & rst_en[g] & PIN_OE[g*PW +: PW]) == '0)
            else $error("return level wrong");
    end

    COV_WRITE: cover property (upd ##1 pending);
    COV_RETURN: cover property (upd ##[1:20] done);
    COV_REWRITE: cover property (pending && upd);
    COV_AXI_RD: cover property (S_AXI_RVALID && S_AXI_RREADY);
endmodule

// ==== tb/ppio_far_end.sv ====
// Far-side model: connector wiring and outside machine hardware
`timescale 1ns/1ps
module ppio_far_end #(
    parameter int NP = 4
) (
    input  wire logic [NP*17-1:0] pin_o,
    input  wire logic [NP*17-1:0] pin_oe,
    input  wire logic [NP*17-1:0] ext_lvl,
    output logic      [NP*17-1:0] pin_i
);
    // Passes both levels
    // Undriven pins, open-collector ones included, show the outside level; driven pins show pin_o
    always_comb begin
        for (int b = 0; b < NP*17; b++) begin
            pin_i[b] = pin_oe[b] ? pin_o[b] : ext_lvl[b];
        end
    end
endmodule

// ==== tb/test_ppio_top.sv ====
// Self-checking bench for the parallel port pin block
`timescale 1ns/1ps
module test_ppio_top;
    import ppio_pkg::*;
    localparam int          NP      = 4;
    localparam int          W       = NP*PW;
    // Port 0 out, 1 in, 2 enhanced, 3 open-collector
    localparam logic [15:0] MODES   = 16'h00E4;
    localparam int          NOUT[NP] = '{12, 4, 12, 8};
    localparam int          RET_N   = (45 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          LIMIT   = 20000;
    logic              clk_sys = 1'b0;
    logic              nrst    = 1'b1;
    logic              ce      = 1'b1;
    logic              update  = 1'b0;
    logic [W-1:0]      pin_i;
    logic [W-1:0]      pin_o;
    logic [W-1:0]      pin_oe;
    logic [W-1:0]      ext_lvl = '1;
    logic [NP-1:0]     epp_req;
    logic [ADDR_W-1:0] awaddr  = '0;
    logic [ADDR_W-1:0] araddr  = '0;
    logic              awvalid = 1'b0;
    logic              wvalid  = 1'b0;
    logic              bready  = 1'b0;
    logic              arvalid = 1'b0;
    logic              rready  = 1'b0;
    logic [31:0]       wdata   = '0;
    logic [3:0]        wstrb   = 4'hF;
    logic              awready, wready, bvalid, arready, rvalid;
    logic [31:0]       rdata;
    logic [1:0]        bresp, rresp;
    int                err_total   = 0;
    int                checks_done = 0;
    int                cycles      = 0;

    ppio_top #(.NPORT(NP), .PORT_MODES(MODES)) u_ppio_top (
        .CLK_SYS(clk_sys), .NRST(nrst), .CE(ce), .UPDATE(update),
        .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE(pin_oe), .EPP_REQ(epp_req),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

    ppio_far_end #(.NP(NP)) u_ppio_far_end (
        .pin_o(pin_o), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_i(pin_i));

    always #5 clk_sys = ~clk_sys;

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            err_total++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [ADDR_W-1:0] pa(int p, logic [4:0] r);
        pa = ADDR_W'(p << PORT_SHIFT) | ADDR_W'(r);
    endfunction

    // Driven pins of each mode, from the pin grouping
    function automatic logic [16:0] om(int p);
        case (MODES[2*p +: 2])
            2'h1: om = 17'h00F00;
            2'h3: om = 17'h000FF;
            default: om = 17'h00FFF;
        endcase
    endfunction

    task automatic axi_wr(logic [ADDR_W-1:0] a, logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awready) begin
                awvalid <= 1'b0;
            end
            if (wready) begin
                wvalid <= 1'b0;
            end
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arready) begin
                arvalid <= 1'b0;
            end
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic rd_chk(logic [ADDR_W-1:0] a, logic [31:0] e, string what);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        chk(what, e, d);
        chk("read resp", {30'h0, RESP_OKAY}, {30'h0, r});
    endtask

    task automatic pulse();
        @(posedge clk_sys);
        update <= 1'b1;
        @(posedge clk_sys);
        update <= 1'b0;
    endtask

    task automatic t_dirs();
        logic [31:0] d;
        logic [1:0]  r;
        for (int p = 0; p < NP; p++) begin
            rd_chk(pa(p, REG_DIR), {15'h0, om(p)}, "dir mask");
            chk("pin enables", {15'h0, om(p)}, {15'h0, pin_oe[p*PW +: PW]});
            chk("output count", NOUT[p], 32'($countones(pin_oe[p*PW +: PW])));
        end
        chk("enhanced request", 32'h4, {28'h0, epp_req});
        axi_rd(pa(NP, REG_DIR), d, r);
        chk("unmapped port resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        axi_wr(pa(1, REG_DIR), 32'h0, r);
        chk("dir write resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        rd_chk(pa(1, REG_DIR), 32'h00000F00, "dir kept");
    endtask

    task automatic t_write();
        logic [1:0] r;
        for (int p = 0; p < NP; p++) begin
            axi_wr(pa(p, REG_OUT), 32'h0001A5C3, r);
            axi_wr(pa(p, REG_INV), 32'h0000F0F0, r);
        end
        pulse();
        #1;
        for (int p = 0; p < NP; p++) begin
            chk("pin out", {15'h0, 17'h0A533 & om(p)}, {15'h0, pin_o[p*PW +: PW]});
        end
    endtask

    task automatic t_inputs();
        // Undriven pins, open-collector control lines included, read the outside level
        ext_lvl <= {NP{17'h15A3C}};
        repeat (3) @(posedge clk_sys);
        pulse();
        for (int p = 0; p < NP; p++) begin
            rd_chk(pa(p, REG_IN), {15'h0, 17'h15A3C & ~om(p)}, "in true");
            rd_chk(pa(p, REG_INN), {15'h0, 17'h0A5C3 & ~om(p)}, "in inverted");
        end
    endtask

    task automatic t_return();
        logic [1:0] r;
        rd_chk(REG_RTIME, RTIME_RESET, "delay reset value");
        axi_wr(REG_RTIME, 32'h89ABCDEF, r);
        chk("write resp", {30'h0, RESP_OKAY}, {30'h0, r});
        rd_chk(REG_RTIME, 32'h89ABCDEF, "delay full width");
        // Only the second byte lane may change
        wstrb <= 4'h2;
        axi_wr(REG_RTIME, 32'h00005500, r);
        wstrb <= 4'hF;
        rd_chk(REG_RTIME, 32'h89AB55EF, "delay byte lane");
        axi_wr(REG_RTIME, 32'h0000002D, r);
        axi_wr(pa(0, REG_OUT), 32'h000000F0, r);
        axi_wr(pa(0, REG_INV), 32'h00000011, r);
        axi_wr(pa(0, REG_RST), 32'h00000013, r);
        pulse();
        repeat (RET_N - 1) @(posedge clk_sys);
        #1;
        chk("before return", 32'hE1, {15'h0, pin_o[16:0]});
        @(posedge clk_sys);
        #1;
        chk("after return", 32'hF1, {15'h0, pin_o[16:0]});
        // A strobe held high restarts the wait each cycle
        @(posedge clk_sys);
        update <= 1'b1;
        repeat (8) @(posedge clk_sys);
        #1;
        chk("held strobe", 32'hE1, {15'h0, pin_o[16:0]});
        @(posedge clk_sys);
        update <= 1'b0;
        rd_chk(REG_STAT, 32'h1, "return pending");
        repeat (RET_N) @(posedge clk_sys);
        rd_chk(REG_STAT, 32'h0, "return done");
        chk("settled pins", 32'hF1, {15'h0, pin_o[16:0]});
    endtask

    // Enable low freezes the delay count; counting resumes where it stopped
    task automatic t_freeze();
        pulse();
        ce <= 1'b0;
        repeat (10) @(posedge clk_sys);
        ce <= 1'b1;
        #1;
        chk("frozen wait", 32'hE1, {15'h0, pin_o[16:0]});
        repeat (RET_N - 1) @(posedge clk_sys);
        #1;
        chk("resumed wait", 32'hE1, {15'h0, pin_o[16:0]});
        @(posedge clk_sys);
        #1;
        chk("resumed return", 32'hF1, {15'h0, pin_o[16:0]});
    endtask

    initial begin
        // Clean falling edge so the reset copy is known before the first clock
        nrst <= 1'b0;
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_dirs();
        t_write();
        t_inputs();
        t_return();
        t_freeze();
        stop_test();
    end
endmodule
